/* common/macl_consts.svh */
// Offsets, field positions, reset values and limits of the accumulator load control
`ifndef MACL_CONSTS_SVH
`define MACL_CONSTS_SVH

`define MACL_A_W          18
`define MACL_B_W          18
`define MACL_P_W          36
`define MACL_ACC_W        52
`define MACL_LAT_W        4
`define MACL_LAT_MAX      12
`define MACL_LAT_TOP_LIN  4'h8
`define MACL_LAT_TWELVE   4'hc

`define MACL_ADDR_W       4
`define MACL_ADDR_CTRL    4'h0
`define MACL_ADDR_STATUS  4'h4
`define MACL_ADDR_ACC_LO  4'h8
`define MACL_ADDR_ACC_HI  4'hc

`define MACL_CTRL_W       21
`define MACL_CTRL_RESET   21'h1e1818
`define MACL_F_SLD_REG    0
`define MACL_F_SLD_CLK    1
`define MACL_F_SLD_CLR    3
`define MACL_F_PIPE_EN    5
`define MACL_F_PIPE_CLK   6
`define MACL_F_PIPE_CLR   8
`define MACL_F_OVF_EN     10
`define MACL_F_LAT        11
`define MACL_F_PROD_CLK   15
`define MACL_F_ACC_CLK    17
`define MACL_F_ACC_CLR    19

`define MACL_ST_OVF       0
`define MACL_ST_SLD       1
`define MACL_ST_LAT       4

`endif

/* common/macl_pkg.sv */
// Types and selection helpers of the accumulator load control
`include "macl_consts.svh"
package macl_pkg;

    typedef enum logic [1:0] {
        MACL_CLK0 = 2'b00,
        MACL_CLK1 = 2'b01,
        MACL_CLK2 = 2'b10,
        MACL_CLK3 = 2'b11
    } macl_clk_sel_t;

    typedef enum logic [1:0] {
        MACL_CLR0     = 2'b00,
        MACL_CLR1     = 2'b01,
        MACL_CLR2     = 2'b10,
        MACL_CLR_NONE = 2'b11
    } macl_clr_sel_t;

    typedef logic signed [`MACL_P_W-1:0]   macl_prod_t;
    typedef logic signed [`MACL_ACC_W-1:0] macl_acc_t;

    // Enable of the chosen clock
    function automatic logic macl_pick_en(input macl_clk_sel_t sel, input logic [3:0] en);
        macl_pick_en = en[sel];
    endfunction

    // Clear of the chosen source; none gives a quiet low
    function automatic logic macl_pick_clr(input macl_clr_sel_t sel, input logic [2:0] clr);
        case (sel)
            MACL_CLR0: macl_pick_clr = clr[0];
            MACL_CLR1: macl_pick_clr = clr[1];
            MACL_CLR2: macl_pick_clr = clr[2];
            default:   macl_pick_clr = 1'b0;
        endcase
    endfunction

endpackage

/* common/macl_lat_if.sv */
// Carrier between the accumulator and its product latency line
`timescale 1ns/1ps
`default_nettype none
`include "macl_consts.svh"
interface macl_lat_if;
    macl_pkg::macl_prod_t     prod_in;
    macl_pkg::macl_prod_t     prod_out;
    logic                     step_en;
    logic [`MACL_LAT_W-1:0]   depth;

    modport src  (output prod_in, output step_en, output depth, input prod_out);
    modport line (input prod_in, input step_en, input depth, output prod_out);
endinterface
`default_nettype wire

/* rtl/macl_lat_line.sv */
// Extra latency stages on the multiplier product
`timescale 1ns/1ps
`default_nettype none
`include "macl_consts.svh"
module macl_lat_line (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   rst_n,
    // Product path
    macl_lat_if.line    lat
);

    macl_pkg::macl_prod_t stage_reg [0:`MACL_LAT_MAX-1];

    // Every stage moves only on the product clock enable
    genvar gi;
    generate
        for (gi = 0; gi < `MACL_LAT_MAX; gi = gi + 1) begin : g_stage
            macl_pkg::macl_prod_t stage_src;
            // Head stage takes the product; no stage below it is ever named
            if (gi == 0) begin : g_head
                assign stage_src = lat.prod_in;
            end else begin : g_tail
                assign stage_src = stage_reg[gi-1];
            end
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    stage_reg[gi] <= '0;
                end else if (lat.step_en) begin
                    stage_reg[gi] <= stage_src;
                end
            end
        end
    endgenerate

    // Depth zero passes the product straight through
    always_comb begin
        if (lat.depth == '0) begin
            lat.prod_out = lat.prod_in;
        end else begin
            lat.prod_out = stage_reg[lat.depth - `MACL_LAT_W'(1)];
        end
    end

endmodule // macl_lat_line
`default_nettype wire

/* rtl/macl_accum.sv */
// Multiply-accumulate stage with synchronous load control
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "macl_consts.svh"
module macl_accum (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // Clock enables of clocks zero to three
    input  wire logic                        clock_enable_zero,
    input  wire logic                        clock_enable_one,
    input  wire logic                        clock_enable_two,
    input  wire logic                        clock_enable_three,
    // Asynchronous clears, active high
    input  wire logic                        async_clear_zero,
    input  wire logic                        async_clear_one,
    input  wire logic                        async_clear_two,
    // Operands and controls from user logic
    input  wire logic signed [`MACL_A_W-1:0] operand_a,
    input  wire logic signed [`MACL_B_W-1:0] operand_b,
    input  wire logic                        add_not_sub,
    input  wire logic                        accum_load,
    // Results
    output logic signed [`MACL_ACC_W-1:0]    accum_result,
    output logic                             accum_overflow,
    // Register port
    input  wire logic [`MACL_ADDR_W-1:0]     reg_addr,
    input  wire logic [31:0]                 reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic [31:0]                      reg_rdata
);

    logic [`MACL_CTRL_W-1:0]      ctrl_reg;
    logic [31:0]                  rdata_reg;
    logic                         sld_in_reg;
    logic                         sld_pipe_reg;
    macl_pkg::macl_acc_t          acc_reg;
    logic                         ovf_reg;

    logic [3:0]                   en_vec;
    logic [2:0]                   clr_vec;

    logic                         cfg_sld_reg;
    macl_pkg::macl_clk_sel_t      cfg_sld_clk;
    macl_pkg::macl_clr_sel_t      cfg_sld_clr;
    logic                         cfg_pipe_en;
    macl_pkg::macl_clk_sel_t      cfg_pipe_clk;
    macl_pkg::macl_clr_sel_t      cfg_pipe_clr;
    logic                         cfg_ovf_en;
    logic [`MACL_LAT_W-1:0]       cfg_lat;
    macl_pkg::macl_clk_sel_t      cfg_prod_clk;
    macl_pkg::macl_clk_sel_t      cfg_acc_clk;
    macl_pkg::macl_clr_sel_t      cfg_acc_clr;

    logic                         sld_in_en;
    logic                         sld_in_clr;
    logic                         sld_pipe_en;
    logic                         sld_pipe_clr;
    logic                         acc_en;
    logic                         acc_clr;
    logic                         prod_en;
    logic [`MACL_LAT_W-1:0]       lat_depth;

    logic                         sld_stage1;
    logic                         sld_eff;
    macl_pkg::macl_prod_t         prod_raw;
    macl_pkg::macl_prod_t         prod_dly;
    logic signed [`MACL_ACC_W:0]  base_ext;
    logic signed [`MACL_ACC_W:0]  prod_ext;
    logic signed [`MACL_ACC_W:0]  sum_next;
    logic                         ovf_next;
    logic [31:0]                  rdata_next;
    logic signed [`MACL_P_W-1:0]  a_ext;
    logic signed [`MACL_P_W-1:0]  b_ext;
    logic                         sign_true;
    logic                         sign_kept;
    logic [31:0]                  status_word;
    logic [31:0]                  acc_hi_word;

    // Product path to the latency line
    macl_lat_if lat_bus ();

    // Enables and clears gathered for the selectors
    assign en_vec  = {clock_enable_three, clock_enable_two,
                      clock_enable_one, clock_enable_zero};
    assign clr_vec = {async_clear_two, async_clear_one, async_clear_zero};

    // Configuration fields
    assign cfg_sld_reg  = ctrl_reg[`MACL_F_SLD_REG];
    assign cfg_sld_clk  = macl_pkg::macl_clk_sel_t'(ctrl_reg[`MACL_F_SLD_CLK +: 2]);
    assign cfg_sld_clr  = macl_pkg::macl_clr_sel_t'(ctrl_reg[`MACL_F_SLD_CLR +: 2]);
    assign cfg_pipe_en  = ctrl_reg[`MACL_F_PIPE_EN];
    assign cfg_pipe_clk = macl_pkg::macl_clk_sel_t'(ctrl_reg[`MACL_F_PIPE_CLK +: 2]);
    assign cfg_pipe_clr = macl_pkg::macl_clr_sel_t'(ctrl_reg[`MACL_F_PIPE_CLR +: 2]);
    assign cfg_ovf_en   = ctrl_reg[`MACL_F_OVF_EN];
    assign cfg_lat      = ctrl_reg[`MACL_F_LAT +: `MACL_LAT_W];
    assign cfg_prod_clk = macl_pkg::macl_clk_sel_t'(ctrl_reg[`MACL_F_PROD_CLK +: 2]);
    assign cfg_acc_clk  = macl_pkg::macl_clk_sel_t'(ctrl_reg[`MACL_F_ACC_CLK +: 2]);
    assign cfg_acc_clr  = macl_pkg::macl_clr_sel_t'(ctrl_reg[`MACL_F_ACC_CLR +: 2]);

    assign sld_in_en    = macl_pkg::macl_pick_en(cfg_sld_clk, en_vec);
    assign sld_in_clr   = macl_pkg::macl_pick_clr(cfg_sld_clr, clr_vec);
    assign sld_pipe_en  = macl_pkg::macl_pick_en(cfg_pipe_clk, en_vec);
    assign sld_pipe_clr = macl_pkg::macl_pick_clr(cfg_pipe_clr, clr_vec);
    assign acc_en       = macl_pkg::macl_pick_en(cfg_acc_clk, en_vec);
    assign acc_clr      = macl_pkg::macl_pick_clr(cfg_acc_clr, clr_vec);
    assign prod_en      = macl_pkg::macl_pick_en(cfg_prod_clk, en_vec);

    always_comb begin
        if (cfg_lat <= `MACL_LAT_TOP_LIN || cfg_lat == `MACL_LAT_TWELVE) begin
            lat_depth = cfg_lat;
        end else begin
            lat_depth = '0;
        end
    end

    // Control register, written whole
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `MACL_CTRL_RESET;
        end else if (reg_wr && reg_addr == `MACL_ADDR_CTRL) begin
            ctrl_reg <= reg_wdata[`MACL_CTRL_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n or posedge sld_in_clr) begin
        if (!rst_n) begin
            sld_in_reg <= 1'b0;
        end else if (sld_in_clr) begin
            sld_in_reg <= 1'b0;
        end else if (sld_in_en) begin
            sld_in_reg <= accum_load;
        end
    end

    // Bypassed input register passes the pin straight on
    assign sld_stage1 = cfg_sld_reg ? sld_in_reg : accum_load;

    always_ff @(posedge clk or negedge rst_n or posedge sld_pipe_clr) begin
        if (!rst_n) begin
            sld_pipe_reg <= 1'b0;
        end else if (sld_pipe_clr) begin
            sld_pipe_reg <= 1'b0;
        end else if (sld_pipe_en) begin
            sld_pipe_reg <= sld_stage1;
        end
    end

    assign sld_eff = cfg_pipe_en ? sld_pipe_reg : sld_stage1;

    // Product and its configurable delay; operands are widened first,
    // since a product of two narrow operands keeps only operand width
    assign a_ext    = `MACL_P_W'(operand_a);
    assign b_ext    = `MACL_P_W'(operand_b);
    assign prod_raw = a_ext * b_ext;

    assign lat_bus.prod_in = prod_raw;
    assign lat_bus.step_en = prod_en;
    assign lat_bus.depth   = lat_depth;
    assign prod_dly        = lat_bus.prod_out;

    macl_lat_line u_lat (
        .clk   (clk),
        .rst_n (rst_n),
        .lat   (lat_bus.line)
    );

    // One extra sign bit catches overflow of the sum
    assign prod_ext = (`MACL_ACC_W+1)'(prod_dly);

    always_comb begin
        if (sld_eff) begin
            base_ext = '0;
        end else begin
            base_ext = {acc_reg[`MACL_ACC_W-1], acc_reg};
        end
    end

    always_comb begin
        if (add_not_sub) begin
            sum_next = base_ext + prod_ext;
        end else begin
            sum_next = base_ext - prod_ext;
        end
    end

    // Sign of the full sum against the sign the register keeps
    assign sign_true = sum_next[`MACL_ACC_W];
    assign sign_kept = sum_next[`MACL_ACC_W-1];

    assign ovf_next = cfg_ovf_en & (sign_true ^ sign_kept);

    always_ff @(posedge clk or negedge rst_n or posedge acc_clr) begin
        if (!rst_n) begin
            acc_reg <= '0;
        end else if (acc_clr) begin
            acc_reg <= '0;
        end else if (acc_en) begin
            acc_reg <= sum_next[`MACL_ACC_W-1:0];
        end
    end

    // Overflow follows the result it belongs to
    always_ff @(posedge clk or negedge rst_n or posedge acc_clr) begin
        if (!rst_n) begin
            ovf_reg <= 1'b0;
        end else if (acc_clr) begin
            ovf_reg <= 1'b0;
        end else if (acc_en) begin
            ovf_reg <= ovf_next;
        end
    end

    // Results straight from their registers
    assign accum_result   = acc_reg;
    assign accum_overflow = ovf_reg;

    // Status word: overflow, effective load, effective latency
    always_comb begin
        status_word = '0;
        status_word[`MACL_ST_OVF] = ovf_reg;
        status_word[`MACL_ST_SLD] = sld_eff;
        status_word[`MACL_ST_LAT +: `MACL_LAT_W] = lat_depth;
    end

    // Upper accumulator bits, zero above the top
    always_comb begin
        acc_hi_word = '0;
        acc_hi_word[`MACL_ACC_W-33:0] = acc_reg[`MACL_ACC_W-1:32];
    end

    // Read mux; unmapped addresses answer zero
    always_comb begin
        rdata_next = '0;
        case (reg_addr)
            `MACL_ADDR_CTRL: begin
                rdata_next[`MACL_CTRL_W-1:0] = ctrl_reg;
            end
            `MACL_ADDR_STATUS: begin
                rdata_next = status_word;
            end
            `MACL_ADDR_ACC_LO: begin
                rdata_next = acc_reg[31:0];
            end
            `MACL_ADDR_ACC_HI: begin
                rdata_next = acc_hi_word;
            end
            default: begin
                rdata_next = '0;
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= '0;
        end else if (reg_rd) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= '0;
        end
    end

    assign reg_rdata = rdata_reg;

endmodule // macl_accum
`default_nettype wire

/* dv/macl_user_model.sv */
// Fabric user logic launching operands and controls into the accumulator
`timescale 1ns/1ps
`default_nettype none
`include "macl_consts.svh"
module macl_user_model (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // Commands from the bench
    input  wire logic signed [`MACL_A_W-1:0] cmd_a,
    input  wire logic signed [`MACL_B_W-1:0] cmd_b,
    input  wire logic                        cmd_add,
    input  wire logic                        cmd_load,
    // Towards the accumulator
    output logic signed [`MACL_A_W-1:0]      op_a,
    output logic signed [`MACL_B_W-1:0]      op_b,
    output logic                             op_add,
    output logic                             op_load
);
    // Launched from flops, as fabric logic would, so levels settle before the edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            op_a <= '0;
            op_b <= '0;
            op_add <= 1'h0;
            op_load <= 1'h0;
        end else begin
            op_a <= cmd_a;
            op_b <= cmd_b;
            op_add <= cmd_add;
            op_load <= cmd_load;
        end
    end
endmodule // macl_user_model
`default_nettype wire

/* dv/macl_accum_asserts.sv */
// Port checks of the accumulator load control
`timescale 1ns/1ps
`default_nettype none
`include "macl_consts.svh"
module macl_accum_asserts (
    // Clock and reset
    input wire logic                          clk,
    input wire logic                          rst_n,
    // Enables and clears
    input wire logic                          clock_enable_zero,
    input wire logic                          clock_enable_one,
    input wire logic                          clock_enable_two,
    input wire logic                          clock_enable_three,
    input wire logic                          async_clear_zero,
    input wire logic                          async_clear_one,
    input wire logic                          async_clear_two,
    // Operands and controls
    input wire logic signed [`MACL_A_W-1:0]   operand_a,
    input wire logic signed [`MACL_B_W-1:0]   operand_b,
    input wire logic                          add_not_sub,
    input wire logic                          accum_load,
    // Results
    input wire logic signed [`MACL_ACC_W-1:0] accum_result,
    input wire logic                          accum_overflow,
    // Register port
    input wire logic [`MACL_ADDR_W-1:0]       reg_addr,
    input wire logic [31:0]                   reg_wdata,
    input wire logic                          reg_wr,
    input wire logic                          reg_rd,
    input wire logic [31:0]                   reg_rdata
);
    logic [`MACL_CTRL_W-1:0] ctrl_reg;
    wire [3:0] ens = {clock_enable_three, clock_enable_two, clock_enable_one, clock_enable_zero};
    // Slot 3 of the clear select means none, so it reads a quiet low
    wire [3:0] clrs = {1'h0, async_clear_two, async_clear_one, async_clear_zero};
    wire acc_en = ens[ctrl_reg[18:17]];
    wire acc_clr = clrs[ctrl_reg[20:19]];
    wire plain = !ctrl_reg[0] && !ctrl_reg[5] && ctrl_reg[14:11] == 4'h0;
    wire step = plain && acc_en && !acc_clr;
    wire signed [`MACL_ACC_W-1:0] prod_w = operand_a * operand_b;

    // Shadow of the control word, to know which clock and clear apply
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `MACL_CTRL_RESET;
        end else if (reg_wr && reg_addr == `MACL_ADDR_CTRL) begin
            ctrl_reg <= reg_wdata[`MACL_CTRL_W-1:0];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_take(logic ld, logic dir);
        step && accum_load == ld && add_not_sub == dir;
    endsequence
    sequence s_ovf_quiet;
        !ctrl_reg[10] && acc_en ##1 !ctrl_reg[10];
    endsequence
    sequence s_wr_rd;
        reg_wr && reg_addr == `MACL_ADDR_CTRL ##1 reg_rd && reg_addr == `MACL_ADDR_CTRL;
    endsequence

    a_clear_zero_now: assert property (acc_clr |-> accum_result == 52'h0)
        else $error("accumulator not cleared");
    a_hold_no_enable: assert property (!acc_en && !acc_clr |=> acc_clr || $stable(accum_result))
        else $error("accumulator moved without enable");
    a_load_adds: assert property (s_take(1'h1, 1'h1) |=> acc_clr || accum_result == $past(prod_w))
        else $error("load did not take product");
    a_load_subs: assert property (s_take(1'h1, 1'h0) |=> acc_clr || accum_result == -$past(prod_w))
        else $error("load did not take negated product");
    a_sum_adds: assert property (s_take(1'h0, 1'h1) |=> acc_clr ||
        accum_result == $past(accum_result) + $past(prod_w)) else $error("sum wrong");
    a_sum_subs: assert property (s_take(1'h0, 1'h0) |=> acc_clr ||
        accum_result == $past(accum_result) - $past(prod_w)) else $error("difference wrong");
    a_ovf_off: assert property (s_ovf_quiet |-> !accum_overflow)
        else $error("overflow flagged while disabled");
    a_ctrl_readback: assert property (s_wr_rd |=> reg_rdata == ($past(reg_wdata, 2) & 32'h1fffff))
        else $error("control readback wrong");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data without read");
endmodule // macl_accum_asserts
bind macl_accum macl_accum_asserts i_macl_accum_asserts (
    .clk(clk), .rst_n(rst_n), .clock_enable_zero(clock_enable_zero),
    .clock_enable_one(clock_enable_one), .clock_enable_two(clock_enable_two),
    .clock_enable_three(clock_enable_three), .async_clear_zero(async_clear_zero),
    .async_clear_one(async_clear_one), .async_clear_two(async_clear_two),
    .operand_a(operand_a), .operand_b(operand_b), .add_not_sub(add_not_sub),
    .accum_load(accum_load), .accum_result(accum_result), .accum_overflow(accum_overflow),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
`default_nettype wire

/* dv/mac_accumulator_load_control_tb_top.sv */
// Self-checking bench of the accumulator load control
`timescale 1ns/1ps
`default_nettype none
`include "macl_consts.svh"
module mac_accumulator_load_control_tb_top;
    logic clk, rst_n, cmd_add, cmd_load, op_add, op_load, reg_wr, reg_rd, ovf_out, q1, q2;
    logic ld, ovf_m;
    logic [3:0] ens;
    logic [2:0] clrs;
    logic signed [`MACL_A_W-1:0] cmd_a, op_a;
    logic signed [`MACL_B_W-1:0] cmd_b, op_b;
    logic signed [`MACL_ACC_W-1:0] acc_out;
    logic [`MACL_ADDR_W-1:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd_val, x;
    logic [31:0] seed = 32'h71bacfa4;
    logic [20:0] cfg, new_cfg;
    longint m_acc, p, s, pq[12];
    int err_total = 0, checked = 0, cyc = 0, lat;
    int lats[10] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 12};
    wire [3:0] cl4 = {1'h0, clrs};

    macl_user_model i_macl_user_model (.clk(clk), .rst_n(rst_n), .cmd_a(cmd_a), .cmd_b(cmd_b),
        .cmd_add(cmd_add), .cmd_load(cmd_load), .op_a(op_a), .op_b(op_b), .op_add(op_add),
        .op_load(op_load));
    macl_accum i_macl_accum (.clk(clk), .rst_n(rst_n), .clock_enable_zero(ens[0]),
        .clock_enable_one(ens[1]), .clock_enable_two(ens[2]), .clock_enable_three(ens[3]),
        .async_clear_zero(clrs[0]), .async_clear_one(clrs[1]), .async_clear_two(clrs[2]),
        .operand_a(op_a), .operand_b(op_b), .add_not_sub(op_add), .accum_load(op_load),
        .accum_result(acc_out), .accum_overflow(ovf_out), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic longint sx52(input longint v);
        return {{12{v[51]}}, v[51:0]};
    endfunction
    task automatic chk_acc(input logic [51:0] e, input logic [51:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("BAD acc expected %h seen %h", e, g);
        end
    endtask
    task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Entered just after a rising edge; leaves the strobe low after the taking edge
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'h0;
        @(negedge clk);
        rd_val = reg_rdata;
        @(posedge clk);
    endtask
    // Clears act before and after the edge: held clears keep their registers empty
    task automatic clr_model;
        if (cl4[cfg[20:19]]) {m_acc, ovf_m} = '0;
        if (cl4[cfg[4:3]]) q1 = 1'h0;
        if (cl4[cfg[9:8]]) q2 = 1'h0;
    endtask

    // Reference datapath, stepped on the design's edges with pre-edge inputs
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg = `MACL_CTRL_RESET;
            {m_acc, ovf_m, q1, q2} = '0;
            foreach (pq[i]) pq[i] = 0;
        end else begin
            lat = cfg[14:11];
            if (lat > 8 && lat != 12) lat = 0;
            clr_model();
            p = (lat == 0) ? longint'(op_a) * op_b : pq[lat-1];
            ld = cfg[5] ? q2 : (cfg[0] ? q1 : op_load);
            if (ens[cfg[18:17]]) begin
                s = (ld ? 0 : m_acc) + (op_add ? p : -p);
                ovf_m = cfg[10] && s != sx52(s);
                m_acc = sx52(s);
            end
            if (ens[cfg[7:6]]) q2 = cfg[0] ? q1 : op_load;
            if (ens[cfg[2:1]]) q1 = op_load;
            if (ens[cfg[16:15]]) begin
                for (int i = 11; i > 0; i--) pq[i] = pq[i-1];
                pq[0] = longint'(op_a) * op_b;
            end
            clr_model();
            if (reg_wr && reg_addr == `MACL_ADDR_CTRL) cfg = reg_wdata[20:0];
        end
    end

    always @(negedge clk) begin
        if (rst_n) begin
            chk_acc(cl4[cfg[20:19]] ? 52'h0 : m_acc[51:0], acc_out);
            chk_reg("ovf", {31'h0, ovf_m && !cl4[cfg[20:19]]}, {31'h0, ovf_out});
        end
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_total++;
            wrap_up();
        end
    end

    initial begin
        {rst_n, ens, clrs, cmd_a, cmd_b, cmd_add, cmd_load} = '0;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        rd(`MACL_ADDR_CTRL);
        chk_reg("ctrl", {11'h0, `MACL_CTRL_RESET}, rd_val);
        wr(`MACL_ADDR_STATUS, 32'hffffffff);
        rd(`MACL_ADDR_CTRL);
        chk_reg("ctrl", {11'h0, `MACL_CTRL_RESET}, rd_val);
        rd(4'h2);
        chk_reg("unmapped", 32'h0, rd_val);
        // Latency code fifteen is no legal depth and must act as zero
        wr(`MACL_ADDR_CTRL, {11'h0, `MACL_CTRL_RESET} | 32'h7800);
        $display("register port test done");
        foreach (lats[r]) begin
            // Zero operands for longer than the deepest delay, so no stale product remains
            {ens, clrs, cmd_a, cmd_b, cmd_load} <= {4'hf, 3'h0, 36'h0, 1'h0};
            repeat (16) @(posedge clk);
            rd(`MACL_ADDR_ACC_LO);
            chk_reg("acc_lo", m_acc[31:0], rd_val);
            rd(`MACL_ADDR_ACC_HI);
            chk_reg("acc_hi", {12'h0, m_acc[51:32]}, rd_val);
            rd(`MACL_ADDR_STATUS);
            chk_reg("status", {24'h0, 4'(lat), 3'h0, ovf_m}, rd_val);
            new_cfg = 21'(xs());
            new_cfg[14:11] = 4'(lats[r]);
            if (!new_cfg[0]) new_cfg[5] = 1'h0;
            if (r == 0) new_cfg[10:0] = 11'h0;
            wr(`MACL_ADDR_CTRL, {11'h0, new_cfg});
            rd(`MACL_ADDR_CTRL);
            chk_reg("ctrl", {11'h0, new_cfg}, rd_val);
            repeat (48) begin
                x = xs();
                ens <= x[3:0] | x[7:4];
                clrs <= (x[12:8] == 5'h0) ? x[15:13] : 3'h0;
                cmd_load <= (x[17:16] == 2'h0);
                cmd_add <= x[18];
                x = xs();
                cmd_a <= x[17:0];
                cmd_b <= x[31:14];
                @(posedge clk);
            end
            $display("round %0d latency %0d done", r, lats[r]);
        end
        wrap_up();
    end
endmodule // mac_accumulator_load_control_tb_top
`default_nettype wire
